/* File: design/moc_meter_output.v */
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "moc_map.vh"

// Contract
// - Bargraph spans the range between programmed top and bottom readings.
// - Four intensity levels shared by bargraph and numeric display; level 4 brightest.
// - Without analog module the menu skips analog span steps; midpoint starts off.
// - Above the analog span the output keeps rising up to converter maximum.
// - Below the analog span the output is clamped at the floor level.
// - Span endpoints take any reading; top below bottom inverts the slope.
// - Span may be two counts wide; the code then steps coarsely.
// - Midpoint mode lights segments between centre and reading; equal lights centre.
// - Blanked readout turns on during programming or viewing, blanks again after.
// - Floor level adjustable within its range and kept below the top level.
// - Top level adjustable within its range and kept above the floor level.
// - Analog output linear: floor at span bottom, top level at span top.
// - Relay 1 energizes after alarm holds for the onset delay; interruption restarts.
// - Relay 1 releases after non-alarm holds for the release delay.
// - Band mode with threshold two above one bounds relay 1 band by both.
// - Band mode, low activation: on below threshold one, off at threshold two.
// - Band mode, high activation: on above threshold two, off at threshold one.
// - Setpoints without relays are still evaluated and indicated.
// - Only setpoint 1 has delays; others switch immediately.
// - Each setpoint has its own deadband enable.
// - Menu order: bar top, bottom, point, intensity, analog top, bottom, midpoint, readout.
// - Module presence sampled at power-up gates analog menu and output.
// - Readings above bargraph top make the bargraph flash.
// - Polarity: high energizes above threshold, low energizes below.
module moc_meter_output #(
   parameter TICK_CYCLES = `MOC_TICK_PERIOD_S * `MOC_NS_PER_S / `MOC_CLK_PERIOD_NS
) (
   input  wire        I_CLK,
   input  wire        I_RST_N,
   input  wire [7:0]  I_ADDR,
   input  wire [15:0] I_WDATA,
   input  wire        I_WR,
   input  wire        I_RD,
   output reg  [15:0] O_RDATA,
   input  wire [15:0] I_READING,
   input  wire        I_READING_VALID,
   input  wire        I_MODULE_PRESENT,
   input  wire        I_BTN_PROG,
   input  wire        I_BTN_ANY,
   output reg  [100:0] O_BAR_SEG,
   output wire [1:0]  O_INTENSITY,
   output wire [2:0]  O_DECIMAL_POINT,
   output wire        O_READOUT_ON,
   output reg  [15:0] O_AN_CODE,
   output wire        O_AN_ENABLE,
   output reg  [3:0]  O_RELAY,
   output wire [3:0]  O_ANNUNC
);

   // Menu steps
   localparam [3:0] ST_IDLE     = 4'h0;
   localparam [3:0] ST_BAR_TOP  = 4'h1;
   localparam [3:0] ST_BAR_BOT  = 4'h2;
   localparam [3:0] ST_POINT    = 4'h3;
   localparam [3:0] ST_BRIGHT   = 4'h4;
   localparam [3:0] ST_AN_TOP   = 4'h5;
   localparam [3:0] ST_AN_BOT   = 4'h6;
   localparam [3:0] ST_MIDPOINT = 4'h7;
   localparam [3:0] ST_READOUT  = 4'h8;

   reg signed [15:0] bar_top;
   reg signed [15:0] bar_bottom;
   reg        [6:0]  numeric_readout_enable_cfg;
   reg signed [15:0] an_top;
   reg signed [15:0] an_bottom;
   reg        [15:0] an_floor;
   reg        [15:0] an_ceil;
   reg signed [15:0] thr [0:3];
   reg        [13:0] onset_delay;
   reg        [13:0] release_delay;
   reg        [8:0]  sp_cfg;
   reg        [3:0]  menu;
   reg        [3:0]  next_menu;
   reg signed [15:0] reading;
   reg        [3:0]  alarm;
   reg        [13:0] delay_cnt;
   reg        [31:0] tick_cnt;
   reg               tick;
   reg               flash;
   reg               present_s1;
   reg               present_s2;
   reg               module_present;
   reg               sampled;
   reg               prog_s1;
   reg               prog_s2;
   reg               prog_d;
   reg               any_s1;
   reg               any_s2;
   integer           k;
   integer           j;

   wire prog_press = prog_s2 & ~prog_d;
   wire signed [15:0] in_reading = I_READING;
   wire wr_floor_ok = (I_WDATA >= `MOC_FLOOR_MIN) && (I_WDATA <= `MOC_FLOOR_MAX)
                      && (I_WDATA < an_ceil);
   wire wr_ceil_ok  = (I_WDATA >= `MOC_CEIL_MIN) && (I_WDATA <= `MOC_CEIL_MAX)
                      && (I_WDATA > an_floor);

   assign O_INTENSITY     = numeric_readout_enable_cfg[`MOC_BRIGHT_MSB:`MOC_BRIGHT_LSB];
   assign O_DECIMAL_POINT = numeric_readout_enable_cfg[`MOC_DP_MSB:`MOC_DP_LSB];
   assign O_READOUT_ON    = numeric_readout_enable_cfg[`MOC_READOUT_BIT] | (menu != ST_IDLE) | any_s2;
   assign O_AN_ENABLE     = module_present;
   assign O_ANNUNC        = O_RELAY;

   // Presence synchroniser runs through reset so the pin is settled at release
   always @(posedge I_CLK) begin
      present_s1 <= I_MODULE_PRESENT;
      present_s2 <= present_s1;
   end

   // Button synchronisers and button edge
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         prog_s1    <= 1'b0;
         prog_s2    <= 1'b0;
         prog_d     <= 1'b0;
         any_s1     <= 1'b0;
         any_s2     <= 1'b0;
      end else begin
         prog_s1    <= I_BTN_PROG;
         prog_s2    <= prog_s1;
         prog_d     <= prog_s2;
         any_s1     <= I_BTN_ANY;
         any_s2     <= any_s1;
      end
   end

   // Module presence caught once after reset release
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         module_present <= 1'b0;
         sampled        <= 1'b0;
      end else if (!sampled) begin
         module_present <= present_s2;
         sampled        <= 1'b1;
      end
   end

   // Menu step order
   always @* begin
      next_menu = menu;
      if (prog_press) begin
         case (menu)
            ST_IDLE:     next_menu = ST_BAR_TOP;
            ST_BAR_TOP:  next_menu = ST_BAR_BOT;
            ST_BAR_BOT:  next_menu = ST_POINT;
            ST_POINT:    next_menu = ST_BRIGHT;
            ST_BRIGHT:   next_menu = module_present ? ST_AN_TOP : ST_MIDPOINT;
            ST_AN_TOP:   next_menu = ST_AN_BOT;
            ST_AN_BOT:   next_menu = ST_MIDPOINT;
            ST_MIDPOINT: next_menu = ST_READOUT;
            ST_READOUT:  next_menu = ST_IDLE;
            default:     next_menu = ST_IDLE;
         endcase
      end
   end

   // Configuration store and menu state
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         menu          <= ST_IDLE;
         bar_top       <= `MOC_RST_BAR_TOP;
         bar_bottom    <= `MOC_RST_BAR_BOTTOM;
         numeric_readout_enable_cfg      <= `MOC_RST_NUMERIC_READOUT_ENABLE_CFG;
         an_top        <= `MOC_RST_AN_TOP;
         an_bottom     <= `MOC_RST_AN_BOTTOM;
         an_floor      <= `MOC_RST_AN_FLOOR;
         an_ceil       <= `MOC_RST_AN_CEIL;
         onset_delay   <= `MOC_RST_DELAY;
         release_delay <= `MOC_RST_DELAY;
         sp_cfg        <= `MOC_RST_SP_CFG;
         for (j = 0; j < 4; j = j + 1) begin
            thr[j] <= `MOC_RST_TH;
         end
      end else begin
         menu <= next_menu;
         if (I_WR) begin
            case (I_ADDR)
               `MOC_REG_BAR_TOP:    bar_top    <= I_WDATA;
               `MOC_REG_BAR_BOTTOM: bar_bottom <= I_WDATA;
               `MOC_REG_NUMERIC_READOUT_ENABLE_CFG:   numeric_readout_enable_cfg   <= I_WDATA[6:0];
               `MOC_REG_AN_TOP:     an_top     <= I_WDATA;
               `MOC_REG_AN_BOTTOM:  an_bottom  <= I_WDATA;
               `MOC_REG_AN_FLOOR: begin
                  if (wr_floor_ok) begin
                     an_floor <= I_WDATA;
                  end
               end
               `MOC_REG_AN_CEIL: begin
                  if (wr_ceil_ok) begin
                     an_ceil <= I_WDATA;
                  end
               end
               `MOC_REG_TH1: thr[0] <= I_WDATA;
               `MOC_REG_TH2: thr[1] <= I_WDATA;
               `MOC_REG_TH3: thr[2] <= I_WDATA;
               `MOC_REG_TH4: thr[3] <= I_WDATA;
               `MOC_REG_ONSET: begin
                  if (I_WDATA[13:0] <= `MOC_DELAY_MAX && I_WDATA[15:14] == 2'b00) begin
                     onset_delay <= I_WDATA[13:0];
                  end
               end
               `MOC_REG_RELEASE: begin
                  if (I_WDATA[13:0] <= `MOC_DELAY_MAX && I_WDATA[15:14] == 2'b00) begin
                     release_delay <= I_WDATA[13:0];
                  end
               end
               `MOC_REG_SP_CFG: sp_cfg <= I_WDATA[8:0];
               default: ;
            endcase
         end
         // Midpoint step opens at off
         if (next_menu == ST_MIDPOINT && menu != ST_MIDPOINT) begin
            numeric_readout_enable_cfg[`MOC_MIDPOINT_BIT] <= 1'b0;
         end
      end
   end

   // Register read, data one cycle later
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_RDATA <= 16'h0000;
      end else if (I_RD) begin
         case (I_ADDR)
            `MOC_REG_BAR_TOP:    O_RDATA <= bar_top;
            `MOC_REG_BAR_BOTTOM: O_RDATA <= bar_bottom;
            `MOC_REG_NUMERIC_READOUT_ENABLE_CFG:   O_RDATA <= {9'h000, numeric_readout_enable_cfg};
            `MOC_REG_AN_TOP:     O_RDATA <= an_top;
            `MOC_REG_AN_BOTTOM:  O_RDATA <= an_bottom;
            `MOC_REG_AN_FLOOR:   O_RDATA <= an_floor;
            `MOC_REG_AN_CEIL:    O_RDATA <= an_ceil;
            `MOC_REG_TH1:        O_RDATA <= thr[0];
            `MOC_REG_TH2:        O_RDATA <= thr[1];
            `MOC_REG_TH3:        O_RDATA <= thr[2];
            `MOC_REG_TH4:        O_RDATA <= thr[3];
            `MOC_REG_ONSET:      O_RDATA <= {2'b00, onset_delay};
            `MOC_REG_RELEASE:    O_RDATA <= {2'b00, release_delay};
            `MOC_REG_SP_CFG:     O_RDATA <= {7'h00, sp_cfg};
            `MOC_REG_STATUS:     O_RDATA <= {6'h00, flash, module_present, O_RELAY, alarm};
            `MOC_REG_MENU:       O_RDATA <= {12'h000, menu};
            default:             O_RDATA <= 16'h0000;
         endcase
      end
   end

   // Seconds tick and flash phase
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b0;
         flash    <= 1'b0;
      end else if (tick_cnt == TICK_CYCLES - 1) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b1;
         flash    <= ~flash;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         tick     <= 1'b0;
      end
   end

   // Bargraph position
   wire signed [16:0] bar_diff = {reading[15], reading} - {bar_bottom[15], bar_bottom};
   wire signed [16:0] bar_span = {bar_top[15], bar_top} - {bar_bottom[15], bar_bottom};
   wire signed [23:0] bar_num  = {{7{bar_diff[16]}}, bar_diff} * `MOC_BAR_SCALE;
   wire signed [23:0] bar_quo  = (bar_span > 17'sd0) ?
                                 bar_num / $signed({{7{bar_span[16]}}, bar_span}) : 24'sd0;
   wire        [6:0]  bar_pos  = (bar_quo < 24'sd0) ? 7'd0 :
                                 (bar_quo > 24'sd100) ? `MOC_BAR_LAST : bar_quo[6:0];
   wire               bar_under = bar_diff < 17'sd0;
   wire               bar_over  = reading > bar_top;
   wire        [6:0]  mid_lo    = (bar_pos < `MOC_BAR_CENTRE) ? bar_pos : `MOC_BAR_CENTRE;
   wire        [6:0]  mid_hi    = (bar_pos > `MOC_BAR_CENTRE) ? bar_pos : `MOC_BAR_CENTRE;

   // Segment lighting pattern
   wire [100:0] seg_lit;
   genvar g;
   generate
      for (g = 0; g <= 100; g = g + 1) begin : g_seg
         assign seg_lit[g] = numeric_readout_enable_cfg[`MOC_MIDPOINT_BIT] ?
                             (g >= mid_lo && g <= mid_hi) :
                             (!bar_under && g <= bar_pos);
      end
   endgenerate

   // Segment flops; overrange blanks the bar on the flash phase
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_BAR_SEG <= {101{1'b0}};
      end else begin
         O_BAR_SEG <= seg_lit & ~{101{bar_over & flash}};
      end
   end

   // Analog scaling
   wire signed [16:0] an_diff = {reading[15], reading} - {an_bottom[15], an_bottom};
   wire signed [16:0] an_span = {an_top[15], an_top} - {an_bottom[15], an_bottom};
   wire signed [16:0] an_gain = {1'b0, an_ceil} - {1'b0, an_floor};
   wire signed [34:0] an_prod = {{18{an_diff[16]}}, an_diff} * {{18{an_gain[16]}}, an_gain};
   wire signed [34:0] an_quo  = (an_span != 17'sd0) ?
                                an_prod / $signed({{18{an_span[16]}}, an_span}) : 35'sd0;
   wire signed [34:0] an_base = {19'h00000, an_floor};
   wire signed [34:0] an_sum  = an_base + an_quo;

   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_AN_CODE <= 16'h0000;
      end else if (!module_present) begin
         O_AN_CODE <= 16'h0000;
      end else if (an_sum < an_base) begin
         O_AN_CODE <= an_floor;
      end else if (an_sum > `MOC_CODE_MAX) begin
         O_AN_CODE <= 16'hffff;
      end else begin
         O_AN_CODE <= an_sum[15:0];
      end
   end

   // Setpoint evaluation on each new reading
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         reading <= 16'h0000;
         alarm   <= 4'h0;
      end else if (I_READING_VALID) begin
         reading <= I_READING;
         for (k = 0; k < 4; k = k + 1) begin
            if (k == 0 && sp_cfg[`MOC_FILL_DRAIN_BIT] && thr[1] > thr[0]) begin
               // Band between threshold one and two
               if (!sp_cfg[`MOC_POLARITY_LSB]) begin
                  if (in_reading < thr[0]) begin
                     alarm[0] <= 1'b1;
                  end else if (in_reading >= thr[1]) begin
                     alarm[0] <= 1'b0;
                  end
               end else begin
                  if (in_reading > thr[1]) begin
                     alarm[0] <= 1'b1;
                  end else if (in_reading <= thr[0]) begin
                     alarm[0] <= 1'b0;
                  end
               end
            end else if (sp_cfg[`MOC_POLARITY_LSB + k]) begin
               // High activation
               if (in_reading > thr[k]) begin
                  alarm[k] <= 1'b1;
               end else if (!sp_cfg[`MOC_DEADBAND_LSB + k] ||
                            in_reading <= thr[k] - `MOC_DEADBAND) begin
                  alarm[k] <= 1'b0;
               end
            end else begin
               // Low activation
               if (in_reading < thr[k]) begin
                  alarm[k] <= 1'b1;
               end else if (!sp_cfg[`MOC_DEADBAND_LSB + k] ||
                            in_reading >= thr[k] + `MOC_DEADBAND) begin
                  alarm[k] <= 1'b0;
               end
            end
         end
      end
   end

   // Relay outputs; only relay 1 is delayed
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_RELAY   <= 4'h0;
         delay_cnt <= 14'h0000;
      end else begin
         O_RELAY[3:1] <= alarm[3:1];
         if (alarm[0] == O_RELAY[0]) begin
            delay_cnt <= 14'h0000;
         end else if (delay_cnt >= (alarm[0] ? onset_delay : release_delay)) begin
            O_RELAY[0] <= alarm[0];
            delay_cnt  <= 14'h0000;
         end else if (tick) begin
            delay_cnt <= delay_cnt + 14'h0001;
         end
      end
   end

endmodule
`default_nettype wire

/* File: inc/moc_map.vh */
`ifndef MOC_MAP_VH
`define MOC_MAP_VH

// Register offsets
`define MOC_REG_BAR_TOP      8'h00
`define MOC_REG_BAR_BOTTOM   8'h04
`define MOC_REG_NUMERIC_READOUT_ENABLE_CFG     8'h08
`define MOC_REG_AN_TOP       8'h0c
`define MOC_REG_AN_BOTTOM    8'h10
`define MOC_REG_AN_FLOOR     8'h14
`define MOC_REG_AN_CEIL      8'h18
`define MOC_REG_TH1          8'h1c
`define MOC_REG_TH2          8'h20
`define MOC_REG_TH3          8'h24
`define MOC_REG_TH4          8'h28
`define MOC_REG_ONSET        8'h2c
`define MOC_REG_RELEASE      8'h30
`define MOC_REG_SP_CFG       8'h34
`define MOC_REG_STATUS       8'h38
`define MOC_REG_MENU         8'h3c

// Display configuration fields
`define MOC_DP_LSB           0
`define MOC_DP_MSB           2
`define MOC_BRIGHT_LSB       3
`define MOC_BRIGHT_MSB       4
`define MOC_MIDPOINT_BIT     5
`define MOC_READOUT_BIT      6

// Setpoint configuration fields
`define MOC_DEADBAND_LSB     0
`define MOC_DEADBAND_MSB     3
`define MOC_POLARITY_LSB     4
`define MOC_POLARITY_MSB     7
`define MOC_FILL_DRAIN_BIT   8

// Reset values
`define MOC_RST_BAR_TOP      16'h270f
`define MOC_RST_BAR_BOTTOM   16'h0000
`define MOC_RST_NUMERIC_READOUT_ENABLE_CFG     7'h58
`define MOC_RST_AN_TOP       16'h270f
`define MOC_RST_AN_BOTTOM    16'h0000
`define MOC_RST_AN_FLOOR     16'h3333
`define MOC_RST_AN_CEIL      16'hcccc
`define MOC_RST_TH           16'h270f
`define MOC_RST_DELAY        14'h0000
`define MOC_RST_SP_CFG       9'h0f0

// Analog code limits for floor and top levels
`define MOC_FLOOR_MIN        16'h0000
`define MOC_FLOOR_MAX        16'hb000
`define MOC_CEIL_MIN         16'hb000
`define MOC_CEIL_MAX         16'hffff
`define MOC_CODE_MAX         35'sh0ffff

// Bargraph geometry
`define MOC_BAR_LAST         7'd100
`define MOC_BAR_CENTRE       7'd50
`define MOC_BAR_SCALE        24'sd100

// Fixed deadband around each threshold, in counts
`define MOC_DEADBAND         16'sd10

// Delay range and timing
`define MOC_DELAY_MAX        14'd9999
`define MOC_TICK_PERIOD_S    1
`define MOC_CLK_PERIOD_NS    40
`define MOC_NS_PER_S         1000000000

`endif

/* File: tb/moc_output_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module moc_output_monitor (
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   input wire logic [7:0]  I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic        I_WR,
   input wire logic        I_RD,
   input wire logic [15:0] O_RDATA,
   input wire logic        I_BTN_ANY,
   input wire logic [1:0]  O_INTENSITY,
   input wire logic [2:0]  O_DECIMAL_POINT,
   input wire logic        O_READOUT_ON,
   input wire logic [15:0] O_AN_CODE,
   input wire logic        O_AN_ENABLE,
   input wire logic [3:0]  O_RELAY,
   input wire logic [3:0]  O_ANNUNC
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   // Indications and relays always agree
   chk_annunc_match: assert property (O_ANNUNC == O_RELAY)
      else $error("annunciators differ from relays");
   chk_intensity_write: assert property (
      I_WR && I_ADDR == 8'h08 |=> {O_INTENSITY, O_DECIMAL_POINT} == $past(I_WDATA[4:0]))
      else $error("intensity or point not taken from write");
   chk_readout_forced: assert property (I_BTN_ANY [*5] |-> O_READOUT_ON)
      else $error("readout blank while button held");
   chk_an_absent: assert property (!O_AN_ENABLE |-> O_AN_CODE == 16'h0000)
      else $error("analog code without module");
   chk_an_stable: assert property ($past(I_RST_N, 3) |-> $stable(O_AN_ENABLE))
      else $error("module record changed after start");
   // Refused writes leave the old value readable
   chk_floor_refused: assert property (
      I_WR && I_ADDR == 8'h14 && I_WDATA > 16'hb000 ##2 I_RD && I_ADDR == 8'h14
      |=> O_RDATA != $past(I_WDATA, 3)) else $error("floor out of range accepted");
   chk_ceil_refused: assert property (
      I_WR && I_ADDR == 8'h18 && I_WDATA < 16'hb000 ##2 I_RD && I_ADDR == 8'h18
      |=> O_RDATA != $past(I_WDATA, 3)) else $error("top out of range accepted");
   chk_delay_refused: assert property (
      I_WR && I_ADDR == 8'h2c && I_WDATA > 16'h270f ##2 I_RD && I_ADDR == 8'h2c
      |=> O_RDATA != $past(I_WDATA, 3)) else $error("delay out of range accepted");
endmodule

bind moc_meter_output moc_output_monitor u_moc_output_monitor (
   .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
   .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_BTN_ANY(I_BTN_ANY),
   .O_INTENSITY(O_INTENSITY), .O_DECIMAL_POINT(O_DECIMAL_POINT),
   .O_READOUT_ON(O_READOUT_ON), .O_AN_CODE(O_AN_CODE), .O_AN_ENABLE(O_AN_ENABLE),
   .O_RELAY(O_RELAY), .O_ANNUNC(O_ANNUNC)
);
`default_nettype wire

/* File: tb/moc_reading_source.sv */
`timescale 1ns/1ps
`default_nettype none
module moc_reading_source (
   input  wire logic        clk,
   input  wire logic        i_go,
   input  wire logic [15:0] i_value,
   input  wire logic [3:0]  i_wait,
   output var  logic [15:0] o_reading,
   output var  logic        o_valid
);
   logic [3:0] cnt = 4'h0;
   logic       busy = 1'b0;
   initial o_reading = 16'h0000;
   initial o_valid = 1'b0;
   // One-cycle reading pulse after a chosen wait; bus toggles when not valid
   always @(posedge clk) begin
      o_valid <= 1'b0;
      o_reading <= ~o_reading;
      if (i_go) begin
         busy <= 1'b1;
         cnt <= i_wait;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (busy) begin
         busy <= 1'b0;
         o_valid <= 1'b1;
         o_reading <= i_value;
      end
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic         I_CLK, I_RST_N, I_WR, I_RD, I_MODULE_PRESENT, I_BTN_PROG, I_BTN_ANY;
   logic         I_READING_VALID, O_READOUT_ON, O_AN_ENABLE, go;
   logic [7:0]   I_ADDR;
   logic [15:0]  I_WDATA, I_READING, O_RDATA, O_AN_CODE, val;
   logic [100:0] O_BAR_SEG;
   logic [1:0]   O_INTENSITY;
   logic [2:0]   O_DECIMAL_POINT;
   logic [3:0]   O_RELAY, O_ANNUNC, dly;
   integer       mismatches = 0, checked = 0, i, r, fl = 13107, ce = 52428;
   integer       sbot = 0, stop = 1000, bbot = 0, btop = 1000;
   integer       st[6] = '{0, 0, 0, 0, 102, 102};
   integer       sb[6] = '{1000, 1000, 1000, 1000, 100, 100};
   integer       sr[6] = '{0, 250, 1200, -100, 101, 103};
   integer       br[7] = '{50, 200, 300, 200, 400, 200, 100};
   logic         be[7] = '{1, 1, 0, 0, 1, 1, 0};

   moc_meter_output #(.TICK_CYCLES(10)) u_moc_meter_output (
      .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_READING(I_READING),
      .I_READING_VALID(I_READING_VALID), .I_MODULE_PRESENT(I_MODULE_PRESENT),
      .I_BTN_PROG(I_BTN_PROG), .I_BTN_ANY(I_BTN_ANY), .O_BAR_SEG(O_BAR_SEG),
      .O_INTENSITY(O_INTENSITY), .O_DECIMAL_POINT(O_DECIMAL_POINT),
      .O_READOUT_ON(O_READOUT_ON), .O_AN_CODE(O_AN_CODE), .O_AN_ENABLE(O_AN_ENABLE),
      .O_RELAY(O_RELAY), .O_ANNUNC(O_ANNUNC));
   moc_reading_source u_moc_reading_source (.clk(I_CLK), .i_go(go), .i_value(val),
      .i_wait(dly), .o_reading(I_READING), .o_valid(I_READING_VALID));

   // Clock
   initial begin
      I_CLK = 1'b0;
      forever #20 I_CLK = ~I_CLK;
   end

   task automatic end_of_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input integer d);
      @(posedge I_CLK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= d[15:0];
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge I_CLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_CLK);
      I_RD <= 1'b0;
      #1 chk("read data", O_RDATA, e);
   endtask

   // One press of the programme button, long enough for the synchroniser
   task automatic press;
      @(posedge I_CLK);
      I_BTN_PROG <= 1'b1;
      repeat (5) @(posedge I_CLK);
      I_BTN_PROG <= 1'b0;
      repeat (5) @(posedge I_CLK);
   endtask

   // Send one reading, return two cycles after the slowest output settles
   task automatic put(input integer v);
      integer n;
      n = 0;
      @(posedge I_CLK);
      go <= 1'b1;
      val <= v[15:0];
      dly <= 4'($urandom_range(3));
      @(posedge I_CLK);
      go <= 1'b0;
      do begin
         @(posedge I_CLK);
         #1 n++;
      end while (I_READING_VALID !== 1'b1 && n < 20);
      repeat (4) @(posedge I_CLK);
      #1;
   endtask

   function automatic integer an_exp(input integer v);
      integer a;
      if (stop == sbot)
         return fl;
      a = fl + (v - sbot) * (ce - fl) / (stop - sbot);
      if (a < fl)
         a = fl;
      if (a > 65535)
         a = 65535;
      return a;
   endfunction

   function automatic logic [127:0] bar_exp(input integer v, input bit mid);
      integer p, lo, hi, k;
      logic [127:0] b;
      p = (v - bbot) * 100 / (btop - bbot);
      p = (p < 0) ? 0 : (p > 100) ? 100 : p;
      lo = mid ? ((p < 50) ? p : 50) : 0;
      hi = mid ? ((p > 50) ? p : 50) : p;
      b = '0;
      for (k = lo; k <= hi; k++)
         b[k] = 1'b1;
      return (!mid && v < bbot) ? '0 : b;
   endfunction

   // Hang guard
   initial begin
      #(40 * 8000);
      mismatches++;
      end_of_test;
   end

   // Main sequence
   initial begin
      {I_RST_N, I_WR, I_RD, I_BTN_PROG, I_BTN_ANY, go} = '0;
      {I_ADDR, I_WDATA, val, dly} = '0;
      I_MODULE_PRESENT = 1'b1;
      void'($urandom(32'h2344));
      repeat (2) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      #1 chk("intensity", O_INTENSITY, 2'd3);
      rd(8'h08, 16'h0058);
      rd(8'h40, 16'h0000);
      wr(8'h14, 16'hb001);
      rd(8'h14, 16'h3333);
      wr(8'h18, 16'hafff);
      rd(8'h18, 16'hcccc);
      wr(8'h2c, 10000);
      rd(8'h2c, 16'h0000);
      chk("module record", O_AN_ENABLE, 1'b1);
      wr(8'h00, 1000); wr(8'h04, 0); wr(8'h0c, 1000); wr(8'h10, 0);
      wr(8'h1c, 1000); wr(8'h20, 200); wr(8'h24, 700); wr(8'h28, -500);
      wr(8'h34, 16'h00b0);
      for (i = 0; i < 16; i++) begin
         r = (i == 0) ? -1999 : (i == 1) ? 9999 : $urandom_range(3000) - 1000;
         put(r);
         chk("analog code", O_AN_CODE, an_exp(r));
         chk("relays", O_RELAY, {r > -500, r < 700, r > 200, r > 1000});
         if (r <= 1000) chk("bar", O_BAR_SEG, bar_exp(r, 0));
      end
      // Overrange bar blinks with the tick
      put(2000);
      r = 0;
      repeat (12) @(posedge I_CLK) #1 r += (O_BAR_SEG == '0);
      chk("bar flash", r > 0 && r < 12, 1'b1);
      for (i = 0; i < 6; i++) begin
         wr(8'h0c, st[i]); wr(8'h10, sb[i]);
         stop = st[i]; sbot = sb[i];
         put(sr[i]);
         chk("analog code", O_AN_CODE, an_exp(sr[i]));
      end
      wr(8'h08, 16'h0078);
      for (i = 0; i < 3; i++) begin
         r = (i == 0) ? 500 : (i == 1) ? 800 : 200;
         put(r);
         chk("centre bar", O_BAR_SEG, bar_exp(r, 1));
      end
      wr(8'h34, 16'h00b4);
      for (i = 0; i < 3; i++) begin
         put(600 + 105 * i - 100 * (i / 2));
         chk("deadband relay", O_RELAY[2], i < 2);
      end
      wr(8'h1c, 100); wr(8'h20, 300); wr(8'h34, 16'h01a0);
      for (i = 0; i < 7; i++) begin
         if (i == 4) wr(8'h34, 16'h01b0);
         put(br[i]);
         chk("band relay", O_RELAY[0], be[i]);
      end
      wr(8'h34, 16'h00b0); wr(8'h1c, 1000); wr(8'h2c, 3); wr(8'h30, 2);
      put(1500);
      repeat (8) @(posedge I_CLK);
      #1 chk("onset early", O_RELAY[0], 1'b0);
      put(500);
      put(1500);
      repeat (10) @(posedge I_CLK);
      #1 chk("onset restart", O_RELAY[0], 1'b0);
      repeat (25) @(posedge I_CLK);
      #1 chk("onset done", O_RELAY[0], 1'b1);
      put(500);
      chk("release early", O_RELAY[0], 1'b1);
      repeat (25) @(posedge I_CLK);
      #1 chk("release done", O_RELAY[0], 1'b0);
      wr(8'h08, 16'h0018);
      #1 chk("readout off", O_READOUT_ON, 1'b0);
      @(posedge I_CLK) I_BTN_ANY <= 1'b1;
      repeat (6) @(posedge I_CLK);
      #1 chk("readout forced", O_READOUT_ON, 1'b1);
      @(posedge I_CLK) I_BTN_ANY <= 1'b0;
      repeat (6) @(posedge I_CLK);
      #1 chk("readout blank again", O_READOUT_ON, 1'b0);
      wr(8'h08, 16'h0078);
      for (i = 1; i < 10; i++) begin
         press;
         rd(8'h3c, 16'(i % 9));
         if (i == 7) rd(8'h08, 16'h0058);
      end
      // Restart without the analog module
      @(posedge I_CLK);
      I_MODULE_PRESENT <= 1'b0;
      I_RST_N <= 1'b0;
      repeat (2) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      repeat (5) press;
      rd(8'h3c, 16'h0007);
      chk("module record", O_AN_ENABLE, 1'b0);
      put(2000);
      chk("analog code", O_AN_CODE, 16'h0000);
      end_of_test;
   end
endmodule
`default_nettype wire
